// ### rtl/ltv_port.sv
/*
 * LCD/TV digital video port: raster timing, 12-bit pixel output, syncs,
 * blank/border flag, reference clock pair, shared TV clock / panel
 * interrupt pin and open-drain two-wire control pins.
 * Assumes a 10 MHz I_CLK; the shared pin and two-wire pins are
 * asynchronous and are synchronised here. Pixels arrive as a stream.
 */
`timescale 1ns/1ps
module ltv_port #(
    parameter int H_ACT = ltv_pkg::H_ACT_DEF,
    parameter int H_BRD = ltv_pkg::H_BRD_DEF,
    parameter int H_FP = ltv_pkg::H_FP_DEF,
    parameter int H_SYNC = ltv_pkg::H_SYNC_DEF,
    parameter int H_BP = ltv_pkg::H_BP_DEF,
    parameter int V_ACT = ltv_pkg::V_ACT_DEF,
    parameter int V_BRD = ltv_pkg::V_BRD_DEF,
    parameter int V_FP = ltv_pkg::V_FP_DEF,
    parameter int V_SYNC = ltv_pkg::V_SYNC_DEF,
    parameter int V_BP = ltv_pkg::V_BP_DEF,
    parameter int REF_HALF = ltv_pkg::REF_HALF_DEF,
    parameter int FIFO_DEPTH = ltv_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // configuration
    input wire logic I_TV_MODE,
    input wire logic I_SINGLE_ENDED,
    input wire logic I_HSYNC_POL,
    input wire logic I_VSYNC_POL,
    input wire logic I_BORDER_IND,
    // pixel stream in
    input wire logic I_PIX_VALID,
    output logic O_PIX_READY,
    input wire logic [ltv_pkg::DATA_W-1:0] I_PIX_DATA,
    // shared tv clock / panel interrupt pin
    input wire logic I_TV_PIXEL_CLOCK_OR_PANEL_IRQ,
    output logic O_PANEL_PULLUP_EN,
    output logic O_PANEL_IRQ,
    // video pins
    output logic [1:0] O_PORT_REFERENCE_CLOCK_PAIR,
    output logic [ltv_pkg::DATA_W-1:0] O_PORT_PIXEL_DATA,
    output logic O_PORT_HORIZONTAL_SYNC,
    output logic O_PORT_VERTICAL_SYNC,
    output logic O_BLANK_BORDER_FLAG_N,
    // two-wire clock pin
    input wire logic I_PORT_TWO_WIRE_CLOCK,
    output logic O_PORT_TWO_WIRE_CLOCK,
    output logic O_PORT_TWO_WIRE_CLOCK_OE,
    // two-wire data pin
    input wire logic I_PORT_TWO_WIRE_DATA,
    output logic O_PORT_TWO_WIRE_DATA,
    output logic O_PORT_TWO_WIRE_DATA_OE,
    // two-wire user side
    input wire logic I_TW_CLOCK_PULL_LOW,
    input wire logic I_TW_DATA_PULL_LOW,
    output logic O_TW_CLOCK_LEVEL,
    output logic O_TW_DATA_LEVEL
);
    localparam int CW = ltv_pkg::CNT_W;
    localparam int DW = ltv_pkg::DATA_W;
    localparam int H_TOT = H_ACT + H_BRD + H_FP + H_SYNC + H_BP + H_BRD;
    localparam int V_TOT = V_ACT + V_BRD + V_FP + V_SYNC + V_BP + V_BRD;
    localparam int H_SS = H_ACT + H_BRD + H_FP;
    localparam int V_SS = V_ACT + V_BRD + V_FP;

    // true when lo <= cnt < hi
    function automatic logic in_range(input logic [CW-1:0] cnt,
                                      input int lo, input int hi);
        in_range = (cnt >= CW'(lo)) && (cnt < CW'(hi));
    endfunction

    // border lies after the active span and before its start
    function automatic logic in_border(input logic [CW-1:0] cnt,
                                       input int act, input int brd,
                                       input int tot);
        in_border = in_range(cnt, act, act + brd) || in_range(cnt, tot - brd, tot);
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [2:0] shared_sync, next_shared_sync;
    logic [1:0] twc_sync, next_twc_sync;
    logic [1:0] twd_sync, next_twd_sync;

    // two stages each; a third stage on the shared pin for edge finding
    always_comb begin
        next_shared_sync = {shared_sync[1:0], I_TV_PIXEL_CLOCK_OR_PANEL_IRQ};
        next_twc_sync = {twc_sync[0], I_PORT_TWO_WIRE_CLOCK};
        next_twd_sync = {twd_sync[0], I_PORT_TWO_WIRE_DATA};
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            shared_sync <= 3'h7;
            twc_sync <= 2'h3;
            twd_sync <= 2'h3;
        end else begin
            shared_sync <= next_shared_sync;
            twc_sync <= next_twc_sync;
            twd_sync <= next_twd_sync;
        end
    end

    // ------------------------------------------------------------
    // reference clock and pixel tick
    // ------------------------------------------------------------
    logic [CW-1:0] ref_div, next_ref_div;
    logic ref_clk, next_ref_clk;
    logic [1:0] ref_pair, next_ref_pair;
    logic pix_tick;

    always_comb begin
        next_ref_div = ref_div + 1'b1;
        next_ref_clk = ref_clk;
        if (ref_div == CW'(REF_HALF - 1)) begin
            next_ref_div = '0;
            next_ref_clk = !ref_clk;
        end
        if (I_TV_MODE) begin
            pix_tick = shared_sync[1] && !shared_sync[2];
        end else begin
            pix_tick = (ref_div == CW'(REF_HALF - 1)) && !ref_clk;
        end
        next_ref_pair[0] = next_ref_clk;
        next_ref_pair[1] = I_SINGLE_ENDED ? ltv_pkg::REF_CLK_RST : !next_ref_clk;
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            ref_div <= '0;
            ref_clk <= ltv_pkg::REF_CLK_RST;
            ref_pair <= {2{ltv_pkg::REF_CLK_RST}};
        end else begin
            ref_div <= next_ref_div;
            ref_clk <= next_ref_clk;
            ref_pair <= next_ref_pair;
        end
    end

    // ------------------------------------------------------------
    // pixel buffer
    // ------------------------------------------------------------
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic fifo_rd_ready;
    logic [DW-1:0] fifo_rd_data;

    pixel_fifo #(
        .W(DW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_wr_valid(I_PIX_VALID),
        .o_wr_ready(fifo_wr_ready),
        .i_wr_data(I_PIX_DATA),
        .o_rd_valid(fifo_rd_valid),
        .i_rd_ready(fifo_rd_ready),
        .o_rd_data(fifo_rd_data)
    );

    // ------------------------------------------------------------
    // raster counters
    // ------------------------------------------------------------
    logic [CW-1:0] h_cnt, next_h_cnt;
    logic [CW-1:0] v_cnt, next_v_cnt;
    logic h_act, v_act, h_brd, v_brd, pix_active;

    // advance one pixel per tick, wrap line then frame
    always_comb begin
        next_h_cnt = h_cnt;
        next_v_cnt = v_cnt;
        if (pix_tick) begin
            if (h_cnt == CW'(H_TOT - 1)) begin
                next_h_cnt = '0;
                next_v_cnt = (v_cnt == CW'(V_TOT - 1)) ? '0 : v_cnt + 1'b1;
            end else begin
                next_h_cnt = h_cnt + 1'b1;
            end
        end
        h_act = in_range(h_cnt, 0, H_ACT);
        v_act = in_range(v_cnt, 0, V_ACT);
        h_brd = in_border(h_cnt, H_ACT, H_BRD, H_TOT);
        v_brd = in_border(v_cnt, V_ACT, V_BRD, V_TOT);
        pix_active = h_act && v_act;
        // one word drains per active pixel
        fifo_rd_ready = pix_tick && pix_active;
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            h_cnt <= '0;
            v_cnt <= '0;
        end else begin
            h_cnt <= next_h_cnt;
            v_cnt <= next_v_cnt;
        end
    end

    // ------------------------------------------------------------
    // video outputs
    // ------------------------------------------------------------
    logic [DW-1:0] pix_data, next_pix_data;
    logic hsync, next_hsync;
    logic vsync, next_vsync;
    logic blank_n, next_blank_n;
    logic marked;

    // outputs change only on a pixel tick
    always_comb begin
        next_pix_data = pix_data;
        next_hsync = hsync;
        next_vsync = vsync;
        next_blank_n = blank_n;
        if (I_BORDER_IND) begin
            marked = (h_act || h_brd) && (v_act || v_brd);
        end else begin
            marked = pix_active;
        end
        if (pix_tick) begin
            next_pix_data = (pix_active && fifo_rd_valid) ? fifo_rd_data : ltv_pkg::DATA_RST;
            next_hsync = in_range(h_cnt, H_SS, H_SS + H_SYNC) ? I_HSYNC_POL : !I_HSYNC_POL;
            next_vsync = in_range(v_cnt, V_SS, V_SS + V_SYNC) ? I_VSYNC_POL : !I_VSYNC_POL;
            next_blank_n = !marked;
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pix_data <= ltv_pkg::DATA_RST;
            hsync <= ltv_pkg::SYNC_RST;
            vsync <= ltv_pkg::SYNC_RST;
            blank_n <= ltv_pkg::BLANK_N_RST;
        end else begin
            pix_data <= next_pix_data;
            hsync <= next_hsync;
            vsync <= next_vsync;
            blank_n <= next_blank_n;
        end
    end

    // ------------------------------------------------------------
    // panel interrupt and two-wire pins
    // ------------------------------------------------------------
    logic irq, next_irq;
    logic pullup_en, next_pullup_en;
    logic twc_oe, next_twc_oe;
    logic twd_oe, next_twd_oe;
    logic twc_lvl, next_twc_lvl;
    logic twd_lvl, next_twd_lvl;

    always_comb begin
        next_pullup_en = !I_TV_MODE;
        next_irq = !I_TV_MODE && !shared_sync[1];
        next_twc_oe = I_TW_CLOCK_PULL_LOW;
        next_twd_oe = I_TW_DATA_PULL_LOW;
        next_twc_lvl = twc_sync[1];
        next_twd_lvl = twd_sync[1];
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            irq <= 1'b0;
            pullup_en <= 1'b0;
            twc_oe <= 1'b0;
            twd_oe <= 1'b0;
            twc_lvl <= 1'b1;
            twd_lvl <= 1'b1;
        end else begin
            irq <= next_irq;
            pullup_en <= next_pullup_en;
            twc_oe <= next_twc_oe;
            twd_oe <= next_twd_oe;
            twc_lvl <= next_twc_lvl;
            twd_lvl <= next_twd_lvl;
        end
    end

    // ------------------------------------------------------------
    // port drive
    // ------------------------------------------------------------
    assign O_PIX_READY = fifo_wr_ready;
    assign O_PANEL_PULLUP_EN = pullup_en;
    assign O_PANEL_IRQ = irq;
    assign O_PORT_REFERENCE_CLOCK_PAIR = ref_pair;
    assign O_PORT_PIXEL_DATA = pix_data;
    assign O_PORT_HORIZONTAL_SYNC = hsync;
    assign O_PORT_VERTICAL_SYNC = vsync;
    assign O_BLANK_BORDER_FLAG_N = blank_n;
    // open-drain pins always drive zero when enabled
    assign O_PORT_TWO_WIRE_CLOCK = 1'b0;
    assign O_PORT_TWO_WIRE_CLOCK_OE = twc_oe;
    assign O_PORT_TWO_WIRE_DATA = 1'b0;
    assign O_PORT_TWO_WIRE_DATA_OE = twd_oe;
    assign O_TW_CLOCK_LEVEL = twc_lvl;
    assign O_TW_DATA_LEVEL = twd_lvl;
endmodule

// ### rtl/ltv_pkg.sv
/*
 * Shared constants for the LCD/TV digital video port: widths, default
 * timing, reset levels and clock figures.
 * Assumes the port logic runs on a single 10 MHz system clock.
 */
package ltv_pkg;
    // ------------------------------------------------------------
    // widths and buffering
    // ------------------------------------------------------------
    localparam int DATA_W = 12;
    localparam int CNT_W = 12;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // clock figures
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int TV_CLK_MIN_HZ = 20_000_000;
    localparam int TV_CLK_MAX_HZ = 40_000_000;
    localparam int TV_DUTY_MIN_PCT = 40;
    localparam int REF_CLK_MAX_HZ = 85_000_000;
    localparam int SE_CLK_MAX_HZ = 65_000_000;
    localparam int REF_HALF_DEF = 2;

    // ------------------------------------------------------------
    // default raster timing, in pixels and lines
    // ------------------------------------------------------------
    localparam int H_ACT_DEF = 8;
    localparam int H_BRD_DEF = 2;
    localparam int H_FP_DEF = 2;
    localparam int H_SYNC_DEF = 2;
    localparam int H_BP_DEF = 2;
    localparam int V_ACT_DEF = 4;
    localparam int V_BRD_DEF = 1;
    localparam int V_FP_DEF = 1;
    localparam int V_SYNC_DEF = 1;
    localparam int V_BP_DEF = 1;

    // ------------------------------------------------------------
    // reset levels
    // ------------------------------------------------------------
    localparam logic [11:0] DATA_RST = 12'h000;
    localparam logic BLANK_N_RST = 1'b1;
    localparam logic SYNC_RST = 1'b0;
    localparam logic REF_CLK_RST = 1'b0;
endpackage

// ### rtl/pixel_fifo.sv
/*
 * Pixel FIFO with valid/ready on both sides and a registered read word.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // fill side
    input wire logic i_wr_valid,
    output logic o_wr_ready,
    input wire logic [W-1:0] i_wr_data,
    // drain side
    output logic o_rd_valid,
    input wire logic i_rd_ready,
    output logic [W-1:0] o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, next_wptr;
    logic [AW-1:0] rptr, next_rptr;
    logic [AW:0] count, next_count;
    logic room, next_room;
    logic rd_valid, next_rd_valid;
    logic push, pop;

    // pointer, level and output stage bookkeeping
    always_comb begin
        push = i_wr_valid && room;
        pop = (count != '0) && (!rd_valid || i_rd_ready);
        next_wptr = push ? wptr + 1'b1 : wptr;
        next_rptr = pop ? rptr + 1'b1 : rptr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
        next_room = (next_count != (AW+1)'(DEPTH));
        if (pop) begin
            next_rd_valid = 1'b1;
        end else if (i_rd_ready) begin
            next_rd_valid = 1'b0;
        end else begin
            next_rd_valid = rd_valid;
        end
    end

    // register state; room is a flop so ready leaves a register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            room <= 1'b1;
            rd_valid <= 1'b0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            room <= next_room;
            rd_valid <= next_rd_valid;
        end
    end

    // storage and registered read word
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wptr] <= i_wr_data;
        end
        if (pop) begin
            o_rd_data <= mem[rptr];
        end
    end

    assign o_wr_ready = room;
    assign o_rd_valid = rd_valid;
endmodule

// ### bench/ltv_port_props.sv
/*
 * Checker for the video port top: pin relations over time.
 * Assumes it is bound to the top with its default raster timing.
 */
`timescale 1ns/1ps
module ltv_port_props #(
    parameter int H_ACT = 8,
    parameter int REF_HALF = 2
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // configuration
    input wire logic I_TV_MODE,
    input wire logic I_SINGLE_ENDED,
    input wire logic I_HSYNC_POL,
    input wire logic I_VSYNC_POL,
    input wire logic I_BORDER_IND,
    // watched pins
    input wire logic I_TV_PIXEL_CLOCK_OR_PANEL_IRQ,
    input wire logic O_PANEL_PULLUP_EN,
    input wire logic O_PANEL_IRQ,
    input wire logic [1:0] O_PORT_REFERENCE_CLOCK_PAIR,
    input wire logic O_PORT_HORIZONTAL_SYNC,
    input wire logic O_BLANK_BORDER_FLAG_N,
    input wire logic O_PORT_TWO_WIRE_CLOCK,
    input wire logic O_PORT_TWO_WIRE_CLOCK_OE,
    input wire logic I_TW_CLOCK_PULL_LOW,
    input wire logic I_PORT_TWO_WIRE_DATA,
    input wire logic O_TW_DATA_LEVEL
);
    // --------
    // helper state
    // --------
    logic [4:0] cfg_prev;
    logic [3:0] age;
    logic [7:0] low_run;
    logic [7:0] ref_same;
    logic flag_prev;
    logic ref_prev;
    logic run_ok;
    wire logic [4:0] cfg = {I_TV_MODE, I_SINGLE_ENDED, I_HSYNC_POL, I_VSYNC_POL, I_BORDER_IND};
    wire logic cfg_chg = (cfg != cfg_prev);
    wire logic settled = (age >= 4'h4) && !cfg_chg;
    wire logic hs_act = (O_PORT_HORIZONTAL_SYNC == I_HSYNC_POL);
    wire logic ref_edge = (O_PORT_REFERENCE_CLOCK_PAIR[0] != ref_prev);
    wire logic flag_rise = O_BLANK_BORDER_FLAG_N && !flag_prev;

    // age since reset or config change, run lengths of flag and ref clock
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cfg_prev <= 5'h00;
            age <= 4'h0;
            low_run <= 8'h00;
            ref_same <= 8'h00;
            flag_prev <= 1'h1;
            ref_prev <= 1'h0;
            run_ok <= 1'h0;
        end else begin
            cfg_prev <= cfg;
            age <= cfg_chg ? 4'h0 : (age == 4'hF ? age : age + 4'h1);
            flag_prev <= O_BLANK_BORDER_FLAG_N;
            ref_prev <= O_PORT_REFERENCE_CLOCK_PAIR[0];
            ref_same <= ref_edge ? 8'h00 : ref_same + 8'h01;
            if (!O_BLANK_BORDER_FLAG_N) begin
                low_run <= flag_prev ? 8'h01 : low_run + 8'h01;
            end
            run_ok <= cfg_chg ? 1'h0 : (flag_prev && !O_BLANK_BORDER_FLAG_N) ? 1'h1 : run_ok;
        end
    end

    // --------
    // assertions
    // --------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST || cfg_chg);

    sequence s_pin_pulled;
        (!I_TV_MODE && !I_TV_PIXEL_CLOCK_OR_PANEL_IRQ) [*4];
    endsequence
    sequence s_hs_pulse;
        hs_act [*8] ##1 !hs_act;
    endsequence

    irq_raise_a: assert property (s_pin_pulled |-> O_PANEL_IRQ)
        else $error("panel request did not raise irq");
    irq_clear_a: assert property ((!I_TV_MODE && I_TV_PIXEL_CLOCK_OR_PANEL_IRQ) [*4]
        |-> !O_PANEL_IRQ)
        else $error("irq high with idle pin");
    pullup_mode_a: assert property (settled |-> O_PANEL_PULLUP_EN == !I_TV_MODE)
        else $error("pull-up does not follow mode");
    tw_drive_a: assert property (settled |-> !O_PORT_TWO_WIRE_CLOCK
        && O_PORT_TWO_WIRE_CLOCK_OE == $past(I_TW_CLOCK_PULL_LOW))
        else $error("two-wire clock drive wrong");
    tw_level_a: assert property (settled |-> O_TW_DATA_LEVEL == $past(I_PORT_TWO_WIRE_DATA, 3))
        else $error("two-wire data level wrong");
    ref_pair_a: assert property (settled |-> (I_SINGLE_ENDED ? !O_PORT_REFERENCE_CLOCK_PAIR[1]
        : ^O_PORT_REFERENCE_CLOCK_PAIR))
        else $error("reference pair relation wrong");
    ref_rate_a: assert property (settled && ref_edge |-> ref_same == REF_HALF - 1)
        else $error("reference clock rate wrong");
    hs_width_a: assert property (settled && !I_TV_MODE && $rose(hs_act) |-> s_hs_pulse)
        else $error("hsync width wrong");
    blank_run_a: assert property (settled && run_ok && flag_rise && !I_TV_MODE && !I_BORDER_IND
        |-> low_run == 2 * REF_HALF * H_ACT)
        else $error("blank run length wrong");
    flag_sync_a: assert property (settled && !O_BLANK_BORDER_FLAG_N |-> !hs_act)
        else $error("flag low during hsync");
endmodule

// ### bench/video_sink_model.sv
/*
 * Far-side model: encoder pixel clock or panel on the shared pin, and
 * pull-ups on the two-wire lines with a far-side pull-down on the data line.
 * Assumes the bench changes its controls away from clock edges.
 */
`timescale 1ns/1ps
module video_sink_model (
    // shared pin control
    input wire logic i_tv_mode,
    input wire logic i_clock_run,
    input wire logic i_duty_long,
    input wire logic i_hot_plug,
    input wire logic i_pullup_en,
    // two-wire pull requests
    input wire logic i_dev_clock_oe,
    input wire logic i_dev_data_oe,
    input wire logic i_far_data_pull,
    // resolved lines
    output logic o_shared_pin,
    output logic o_tw_clock,
    output logic o_tw_data
);
    logic tv_clk = 1'h0;
    logic float_pat = 1'h0;

    // 800 ns clock, 60/40 or 40/60 duty, still when stopped
    initial begin
        forever begin
            if (i_clock_run) begin
                tv_clk = 1'h1;
                #(i_duty_long ? 480 : 320);
                tv_clk = 1'h0;
                #(i_duty_long ? 320 : 480);
            end else begin
                #100;
            end
        end
    end

    // changing level on an undriven pin with no pull-up
    initial forever #70 float_pat = ~float_pat;

    // panel pulls the shared pin low on hot plug
    assign o_shared_pin = i_tv_mode ? tv_clk : (i_hot_plug ? 1'h0 : (i_pullup_en ? 1'h1 : float_pat));
    assign o_tw_clock = !i_dev_clock_oe;
    assign o_tw_data = !(i_dev_data_oe || i_far_data_pull);
endmodule

// ### bench/tb_top.sv
/*
 * Bench for the video port: reset levels, panel irq, two-wire pins,
 * reference clock, raster flag and syncs, FIFO fill and TV drain.
 * Assumes default raster timing and a 10 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int TICK = 2 * ltv_pkg::REF_HALF_DEF;
    localparam int HL = ltv_pkg::H_ACT_DEF + 2 * ltv_pkg::H_BRD_DEF + ltv_pkg::H_FP_DEF
        + ltv_pkg::H_SYNC_DEF + ltv_pkg::H_BP_DEF;
    localparam int VL = ltv_pkg::V_ACT_DEF + 2 * ltv_pkg::V_BRD_DEF + ltv_pkg::V_FP_DEF
        + ltv_pkg::V_SYNC_DEF + ltv_pkg::V_BP_DEF;
    localparam int FRAME = HL * VL * TICK;
    localparam int ACT_LOW = ltv_pkg::H_ACT_DEF * ltv_pkg::V_ACT_DEF * TICK;
    localparam int BRD_LOW = (ltv_pkg::H_ACT_DEF + 2 * ltv_pkg::H_BRD_DEF)
        * (ltv_pkg::V_ACT_DEF + 2 * ltv_pkg::V_BRD_DEF) * TICK;
    localparam int HS_ACT = ltv_pkg::H_SYNC_DEF * VL * TICK;
    localparam int VS_ACT = ltv_pkg::V_SYNC_DEF * HL * TICK;
    logic clk = 1'h0, nrst = 1'h0, tv_mode = 1'h0, single_ended = 1'h0, pol = 1'h0;
    logic border_ind = 1'h0, pix_valid = 1'h0, hot_plug = 1'h0, clock_run = 1'h0;
    logic duty_long = 1'h0, tw_clock_pull = 1'h0, tw_data_pull = 1'h0, far_data_pull = 1'h0;
    logic capture = 1'h0, ref_last;
    logic [ltv_pkg::DATA_W-1:0] pix_data = 12'h000, pix_out, last_out;
    logic pix_ready, pullup_en, irq, hs, vs, flag_n, clock_o, clock_oe, data_o, data_oe;
    logic clock_level, data_level, shared_pin, tw_clock, tw_data;
    logic [1:0] ref_pair;
    logic [11:0] seen[$];
    int errors = 0, comparisons = 0, fill = 0, edges;

    ltv_port i_ltv_port (
        .I_CLK(clk), .I_NRST(nrst), .I_TV_MODE(tv_mode), .I_SINGLE_ENDED(single_ended),
        .I_HSYNC_POL(pol), .I_VSYNC_POL(pol), .I_BORDER_IND(border_ind),
        .I_PIX_VALID(pix_valid), .O_PIX_READY(pix_ready), .I_PIX_DATA(pix_data),
        .I_TV_PIXEL_CLOCK_OR_PANEL_IRQ(shared_pin), .O_PANEL_PULLUP_EN(pullup_en),
        .O_PANEL_IRQ(irq), .O_PORT_REFERENCE_CLOCK_PAIR(ref_pair), .O_PORT_PIXEL_DATA(pix_out),
        .O_PORT_HORIZONTAL_SYNC(hs), .O_PORT_VERTICAL_SYNC(vs), .O_BLANK_BORDER_FLAG_N(flag_n),
        .I_PORT_TWO_WIRE_CLOCK(tw_clock), .O_PORT_TWO_WIRE_CLOCK(clock_o),
        .O_PORT_TWO_WIRE_CLOCK_OE(clock_oe), .I_PORT_TWO_WIRE_DATA(tw_data),
        .O_PORT_TWO_WIRE_DATA(data_o), .O_PORT_TWO_WIRE_DATA_OE(data_oe),
        .I_TW_CLOCK_PULL_LOW(tw_clock_pull), .I_TW_DATA_PULL_LOW(tw_data_pull),
        .O_TW_CLOCK_LEVEL(clock_level), .O_TW_DATA_LEVEL(data_level));

    video_sink_model i_video_sink_model (
        .i_tv_mode(tv_mode), .i_clock_run(clock_run), .i_duty_long(duty_long),
        .i_hot_plug(hot_plug), .i_pullup_en(pullup_en), .i_dev_clock_oe(clock_oe),
        .i_dev_data_oe(data_oe), .i_far_data_pull(far_data_pull),
        .o_shared_pin(shared_pin), .o_tw_clock(tw_clock), .o_tw_data(tw_data));

    // 10 MHz system clock
    initial forever #50 clk = ~clk;

    // --------
    // helper tasks
    // --------
    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // one frame of flag and sync counts for one configuration
    task automatic frame(input int k);
        int low = 0;
        int hsn = 0;
        int vsn = 0;
        border_ind = k[0];
        pol = k[1];
        cyc(8);
        repeat (FRAME) begin
            @(negedge clk);
            low += int'(!flag_n);
            hsn += int'(hs);
            vsn += int'(vs);
        end
        check(12'(low), 12'(k[0] ? BRD_LOW : ACT_LOW), "flag low count");
        check(12'(hsn), 12'(k[1] ? HS_ACT : FRAME - HS_ACT), "hsync count");
        check(12'(vsn), 12'(k[1] ? VS_ACT : FRAME - VS_ACT), "vsync count");
    endtask

    // record each new word seen on the data pins
    always @(negedge clk) begin
        if (capture && pix_out !== last_out && pix_out !== 12'h000) begin
            seen.push_back(pix_out);
        end
        last_out = pix_out;
    end

    // --------
    // main sequence
    // --------
    initial begin
        cyc(4);
        check(flag_n, 1'h1, "flag in reset");
        check(ref_pair, 2'h0, "ref pair in reset");
        check(pix_out, 12'h000, "data in reset");
        cyc(4);
        nrst = 1'h1;
        cyc(4);
        check(pullup_en, 1'h1, "pull-up off in panel mode");
        check(irq, 1'h0, "irq with idle pin");
        hot_plug = 1'h1;
        cyc(5);
        check(irq, 1'h1, "irq not raised");
        hot_plug = 1'h0;
        cyc(5);
        check(irq, 1'h0, "irq stuck");
        tw_clock_pull = 1'h1;
        far_data_pull = 1'h1;
        cyc(5);
        check({clock_o, data_o, clock_oe, data_oe}, 4'h2, "two-wire drive");
        check({clock_level, data_level}, 2'h0, "two-wire levels");
        tw_clock_pull = 1'h0;
        far_data_pull = 1'h0;
        tw_data_pull = 1'h1;
        cyc(5);
        check({clock_oe, data_oe, clock_level, data_level}, 4'h6, "two-wire swap");
        tw_data_pull = 1'h0;
        for (int se = 0; se < 2; se++) begin
            single_ended = se[0];
            edges = 0;
            cyc(4);
            repeat (16) begin
                ref_last = ref_pair[0];
                @(negedge clk);
                edges += int'(ref_pair[0] != ref_last);
                check(ref_pair[1], se ? 1'h0 : !ref_pair[0], "ref pair bit one");
            end
            check(12'(edges), 12'(16 / ltv_pkg::REF_HALF_DEF), "ref clock rate");
        end
        for (int k = 0; k < 4; k++) begin
            frame(k);
        end
        tv_mode = 1'h1;
        border_ind = 1'h0;
        cyc(8);
        while (pix_ready === 1'h1 && fill < 40) begin
            pix_valid = 1'h1;
            pix_data = 12'hA01 + 12'(fill);
            fill++;
            @(negedge clk);
        end
        pix_data = 12'hFFF;
        cyc(4);
        pix_valid = 1'h0;
        check(12'(fill), 12'(ltv_pkg::FIFO_DEPTH + 1), "words accepted");
        check(pix_ready, 1'h0, "ready while full");
        capture = 1'h1;
        clock_run = 1'h1;
        duty_long = 1'h1;
        cyc(1500);
        duty_long = 1'h0;
        cyc(1500);
        check(pix_ready, 1'h1, "ready after drain");
        check(12'(seen.size()), 12'(ltv_pkg::FIFO_DEPTH + 1), "words shown");
        foreach (seen[i]) begin
            check(seen[i], 12'hA01 + 12'(i), "word order");
        end
        end_of_test();
    end

    // watchdog well past the expected run length
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: timeout", $time);
        end_of_test();
    end
endmodule

bind ltv_port ltv_port_props #(.H_ACT(H_ACT), .REF_HALF(REF_HALF)) i_ltv_port_props (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_TV_MODE(I_TV_MODE), .I_SINGLE_ENDED(I_SINGLE_ENDED),
    .I_HSYNC_POL(I_HSYNC_POL), .I_VSYNC_POL(I_VSYNC_POL), .I_BORDER_IND(I_BORDER_IND),
    .I_TV_PIXEL_CLOCK_OR_PANEL_IRQ(I_TV_PIXEL_CLOCK_OR_PANEL_IRQ),
    .O_PANEL_PULLUP_EN(O_PANEL_PULLUP_EN), .O_PANEL_IRQ(O_PANEL_IRQ),
    .O_PORT_REFERENCE_CLOCK_PAIR(O_PORT_REFERENCE_CLOCK_PAIR),
    .O_PORT_HORIZONTAL_SYNC(O_PORT_HORIZONTAL_SYNC), .O_BLANK_BORDER_FLAG_N(O_BLANK_BORDER_FLAG_N),
    .O_PORT_TWO_WIRE_CLOCK(O_PORT_TWO_WIRE_CLOCK),
    .O_PORT_TWO_WIRE_CLOCK_OE(O_PORT_TWO_WIRE_CLOCK_OE),
    .I_TW_CLOCK_PULL_LOW(I_TW_CLOCK_PULL_LOW), .I_PORT_TWO_WIRE_DATA(I_PORT_TWO_WIRE_DATA),
    .O_TW_DATA_LEVEL(O_TW_DATA_LEVEL));
